//--- bench/bus_sink.sv
// memory side model that takes write beats with periodic stalls
`timescale 1ns/1ns
`default_nettype none
module bus_sink
  import wcb_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              bus_valid_in,
  input  wire logic [ADDR_W-1:0] bus_addr_in,
  input  wire logic [7:0]        bus_be_in,
  input  wire logic [63:0]       bus_data_in,
  input  wire logic              bus_burst_in,
  input  wire logic              bus_last_in,
  output logic                   bus_ready_out
);
  // ***********************************
  // stall and capture
  // ***********************************
  logic [ADDR_W-1:0] addr_q[$];
  logic [9:0]        flag_q[$];
  logic [63:0]       data_q[$];
  logic [1:0]        tick_reg;
  initial tick_reg = 2'h0;
  initial bus_ready_out = 1'b0;
  // one stall in four, so the sender must hold its beat
  always @(negedge core_clk_in) begin
    tick_reg <= tick_reg + 2'h1;
    bus_ready_out <= (tick_reg != 2'h2);
  end
  always @(posedge core_clk_in) begin
    if (bus_valid_in && bus_ready_out) begin
      addr_q.push_back(bus_addr_in);
      flag_q.push_back({bus_burst_in, bus_last_in, bus_be_in});
      data_q.push_back(bus_data_in);
    end
  end
endmodule : bus_sink
`default_nettype wire

//--- bench/write_combining_buffer_bench.sv
// self-checking bench of the write-combining buffer
`timescale 1ns/1ns
`default_nettype none
module write_combining_buffer_bench;
  import wcb_pkg::*;
  // ***********************************
  // signals and instances
  // ***********************************
  logic        core_clk_in, resetn_in, st_valid_in, st_ready_out;
  logic [31:0] st_addr_in, ld_addr_in, bus_addr_out;
  logic [1:0]  st_size_in;
  logic [2:0]  st_type_in, ld_type_in;
  logic [63:0] st_data_in, bus_data_out;
  logic [4:0]  ev;
  logic        ld_valid_in, bus_ready_in, bus_valid_out;
  logic [7:0]  bus_be_out;
  logic        bus_burst_out, bus_last_out, combining_open_out;
  int          errors, num_checks;
  write_combining_buffer DUT (.core_clk_in(core_clk_in),
    .resetn_in(resetn_in), .st_valid_in(st_valid_in),
    .st_ready_out(st_ready_out), .st_addr_in(st_addr_in),
    .st_size_in(st_size_in), .st_type_in(st_type_in),
    .st_data_in(st_data_in), .io_op_in(ev[0]), .serialize_in(ev[1]),
    .flush_in(ev[2]), .lock_start_in(ev[3]), .tlb_ad_set_in(ev[4]),
    .ld_valid_in(ld_valid_in), .ld_type_in(ld_type_in),
    .ld_addr_in(ld_addr_in), .bus_ready_in(bus_ready_in),
    .bus_valid_out(bus_valid_out), .bus_addr_out(bus_addr_out),
    .bus_be_out(bus_be_out), .bus_data_out(bus_data_out),
    .bus_burst_out(bus_burst_out), .bus_last_out(bus_last_out),
    .combining_open_out(combining_open_out));
  bus_sink sink (.core_clk_in(core_clk_in), .bus_valid_in(bus_valid_out),
    .bus_addr_in(bus_addr_out), .bus_be_in(bus_be_out),
    .bus_data_in(bus_data_out), .bus_burst_in(bus_burst_out),
    .bus_last_in(bus_last_out), .bus_ready_out(bus_ready_in));
  // ***********************************
  // shared tasks
  // ***********************************
  task automatic chk(input string n, input logic [63:0] e, g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // holds the request until taken, then waits out the stall
  task automatic store(input logic [31:0] a, input logic [1:0] s,
                       input logic [2:0] t, input logic [63:0] d);
    @(negedge core_clk_in);
    {st_valid_in, st_addr_in, st_size_in, st_type_in} = {1'b1, a, s, t};
    st_data_in = d;
    // ready seen here is what the next rising edge samples
    while (st_ready_out !== 1'b1) @(negedge core_clk_in);
    @(negedge core_clk_in);
    st_valid_in = 1'b0;
    while (st_ready_out !== 1'b1) @(negedge core_clk_in);
  endtask : store
  task automatic pulse(input int i);
    @(negedge core_clk_in);
    ev = 5'h01 << i;
    @(negedge core_clk_in);
    ev = 5'h00;
  endtask : pulse
  task automatic load(input logic [2:0] t, input logic [31:0] a);
    @(negedge core_clk_in);
    {ld_valid_in, ld_type_in, ld_addr_in} = {1'b1, t, a};
    @(negedge core_clk_in);
    ld_valid_in = 1'b0;
  endtask : load
  // data compared only in enabled lanes
  task automatic beat(input logic [31:0] a, input logic [9:0] f,
                      input logic [63:0] d);
    int          k;
    logic [63:0] m;
    k = 0;
    while (sink.addr_q.size() == 0 && k < 300) begin
      @(posedge core_clk_in);
      k++;
    end
    if (sink.addr_q.size() == 0) chk("beat", 64'h1, 64'h0);
    else begin
      for (int b = 0; b < 8; b++) m[8*b +: 8] = {8{f[b]}};
      chk("addr", a, sink.addr_q.pop_front());
      chk("flags", f, sink.flag_q.pop_front());
      chk("data", d & m, sink.data_q.pop_front() & m);
    end
  endtask : beat
  // ***********************************
  // scenarios
  // ***********************************
  task automatic t_full;
    for (int q = 7; q >= 0; q--)
      store(32'h100 + 8*q, 2'h3, combining_memory_type,
            64'h0101010101010101 * q);
    for (int q = 0; q < 8; q++)
      beat(32'h100 + 8*q, {1'b1, q == 7, 8'hFF},
           64'h0101010101010101 * q);
  endtask : t_full
  task automatic t_wt;
    for (int k = 0; k < 5; k++)
      store(32'h203 + k, 2'h0, writethrough_memory_type, 64'h3 + k);
    beat(32'h200, 10'h1F8, 64'h0706050403000000);
    store(32'h300, 2'h0, writethrough_memory_type, 64'h11);
    store(32'h302, 2'h0, writethrough_memory_type, 64'h22);
    beat(32'h300, 10'h101, 64'h11);
    repeat (12) @(posedge core_clk_in);
    chk("open_before", 64'h1, combining_open_out);
    repeat (8) @(posedge core_clk_in);
    chk("open_after", 64'h0, combining_open_out);
    beat(32'h300, 10'h104, 64'h220000);
    store(32'h806, 2'h2, writethrough_memory_type, 64'h44332211);
    beat(32'h800, 10'h1C0, 64'h2211000000000000);
    pulse(2);
    beat(32'h808, 10'h103, 64'h4433);
  endtask : t_wt
  task automatic t_events;
    for (int i = 0; i < 7; i++) begin
      store(32'h400 + 64*i, 2'h0, combining_memory_type, 64'hA5);
      if (i < 5) pulse(i);
      else if (i == 5) load(uncacheable_memory_type, 32'h0);
      else begin
        load(combining_memory_type, 32'h900);
        repeat (2) @(posedge core_clk_in);
        chk("load_other", 64'h1, combining_open_out);
        load(combining_memory_type, 32'h400 + 64*i);
      end
      beat(32'h400 + 64*i, 10'h101, 64'hA5);
    end
  endtask : t_events
  task automatic t_types;
    store(32'h500, 2'h0, combining_memory_type, 64'h01);
    store(32'h508, 2'h0, writethrough_memory_type, 64'h02);
    beat(32'h500, 10'h101, 64'h01);
    store(32'h510, 2'h0, uncacheable_memory_type, 64'h03);
    beat(32'h508, 10'h101, 64'h02);
    beat(32'h510, 10'h101, 64'h03);
    store(32'h511, 2'h0, write_protected_memory_type, 64'h04);
    beat(32'h510, 10'h102, 64'h0400);
    store(32'h600, 2'h0, combining_memory_type, 64'h05);
    store(32'h700, 2'h0, writeback_memory_type, 64'h06);
    chk("wb_ignored", 64'h1, combining_open_out);
    store(32'h601, 2'h0, combining_memory_type, 64'h07);
    store(32'h640, 2'h0, combining_memory_type, 64'h08);
    beat(32'h600, 10'h103, 64'h0705);
    store(32'h602, 2'h0, combining_memory_type, 64'h09);
    beat(32'h640, 10'h101, 64'h08);
    pulse(2);
    beat(32'h600, 10'h104, 64'h090000);
  endtask : t_types
  // ***********************************
  // clock, reset, verdict
  // ***********************************
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  initial begin
    #400000;
    errors++;
    test_done();
  end
  initial begin
    {resetn_in, st_valid_in, ld_valid_in, ev} = 8'h00;
    {st_addr_in, ld_addr_in, st_size_in, st_type_in, ld_type_in} = 72'h0;
    st_data_in = 64'h0;
    errors = 0;
    num_checks = 0;
    repeat (16) @(negedge core_clk_in);
    resetn_in = 1'b1;
    repeat (2) @(posedge core_clk_in);
    t_full();
    t_wt();
    t_events();
    t_types();
    test_done();
  end
endmodule : write_combining_buffer_bench
`default_nettype wire

//--- common/wcb_drain_if.sv
// hand-over of a closed line from the combiner to the bus write sender
`timescale 1ns/1ns
`default_nettype none
interface wcb_drain_if;
  import wcb_pkg::*;
  logic                     start;
  logic                     busy;
  logic [LINE_W-1:0]        line;
  logic [LINE_QW-1:0][63:0] data;
  logic [LINE_QW-1:0][7:0]  mask;
  modport src (output start, line, data, mask, input busy);
  modport dst (input start, line, data, mask, output busy);
endinterface : wcb_drain_if
`default_nettype wire

//--- common/wcb_pkg.sv
// shared constants and types of the write-combining buffer
package wcb_pkg;
  localparam int ADDR_W  = 32;
  localparam int LINE_QW = 8;
  localparam int LINE_W  = ADDR_W - 6;
  localparam int QA_W    = ADDR_W - 3;
  localparam logic [4:0] WT_TIMEOUT_CLKS = 5'h10;
  localparam logic [2:0] WT_LAST_BYTE    = 3'h7;
  localparam logic [7:0] QW_ALL_BYTES    = 8'hFF;
  localparam logic [3:0] DRAIN_END       = 4'h8;
  localparam logic [4:0] CNT_RST         = 5'h00;
  typedef enum logic [2:0] {
    uncacheable_memory_type     = 3'h0,
    combining_memory_type       = 3'h1,
    writethrough_memory_type    = 3'h4,
    write_protected_memory_type = 3'h5,
    writeback_memory_type       = 3'h6
  } mem_type_type;
endpackage : wcb_pkg

//--- design/bus_write_sender.sv
// walks a closed line and issues its quadword or full-line bus writes
`timescale 1ns/1ns
`default_nettype none
module bus_write_sender
  import wcb_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              resetn_in,
  wcb_drain_if.dst               drn,
  input  wire logic              bus_ready_in,
  output logic                   bus_valid_out,
  output logic      [ADDR_W-1:0] bus_addr_out,
  output logic      [7:0]        bus_be_out,
  output logic      [63:0]       bus_data_out,
  output logic                   bus_burst_out,
  output logic                   bus_last_out
);
  typedef enum {DR_IDLE, DR_SCAN} drain_state_type;
  drain_state_type   state_reg, state_next;
  logic [3:0]        ptr_reg, ptr_next;
  logic              valid_reg, valid_next, burst_reg, burst_next;
  logic              last_reg, last_next, busy_reg, busy_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [7:0]        be_reg, be_next;
  logic [63:0]       data_reg, data_next;
  logic              more;
  logic              full;

  // ********************
  // beat selection
  // ********************
  always_comb begin
    full = 1'b1;
    more = 1'b0;
    for (int q = 0; q < LINE_QW; q++) begin
      full = full & (drn.mask[q] == QW_ALL_BYTES);
      if (q > int'(ptr_reg) && drn.mask[q] != 8'h00) begin
        more = 1'b1;
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    ptr_next   = ptr_reg;
    valid_next = valid_reg;
    burst_next = burst_reg;
    last_next  = last_reg;
    addr_next  = addr_reg;
    be_next    = be_reg;
    data_next  = data_reg;
    if (!(valid_reg && !bus_ready_in)) begin
      valid_next = 1'b0;
      unique case (state_reg)
        DR_IDLE: begin
          if (drn.start) begin
            burst_next = full;
            ptr_next   = 4'h0;
            state_next = DR_SCAN;
          end
        end
        DR_SCAN: begin
          if (ptr_reg == DRAIN_END) begin
            state_next = DR_IDLE;
          end else begin
            // empty quadwords are skipped, partial ones masked
            if (drn.mask[ptr_reg[2:0]] != 8'h00) begin
              valid_next = 1'b1;
              addr_next  = {drn.line, ptr_reg[2:0], 3'h0};
              be_next    = drn.mask[ptr_reg[2:0]];
              data_next  = drn.data[ptr_reg[2:0]];
              last_next  = !more;
            end
            ptr_next = ptr_reg + 4'h1;
          end
        end
      endcase
    end
    busy_next = (state_next != DR_IDLE) || valid_next;
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      state_reg <= DR_IDLE;
      ptr_reg   <= 4'h0;
      valid_reg <= 1'b0;
      burst_reg <= 1'b0;
      last_reg  <= 1'b0;
      busy_reg  <= 1'b0;
      addr_reg  <= '0;
      be_reg    <= 8'h00;
      data_reg  <= '0;
    end else begin
      state_reg <= state_next;
      ptr_reg   <= ptr_next;
      valid_reg <= valid_next;
      burst_reg <= burst_next;
      last_reg  <= last_next;
      busy_reg  <= busy_next;
      addr_reg  <= addr_next;
      be_reg    <= be_next;
      data_reg  <= data_next;
    end
  end

  assign drn.busy      = busy_reg;
  assign bus_valid_out = valid_reg;
  assign bus_addr_out  = addr_reg;
  assign bus_be_out    = be_reg;
  assign bus_data_out  = data_reg;
  assign bus_burst_out = burst_reg;
  assign bus_last_out  = last_reg;

  a_burst_all_bytes: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    valid_reg && burst_reg |-> be_reg == QW_ALL_BYTES)
    else $error("full-line write with partial byte enables");
  a_beat_held: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    valid_reg && !bus_ready_in |=> valid_reg && $stable(addr_reg))
    else $error("bus beat dropped before acceptance");
endmodule : bus_write_sender
`default_nettype wire

//--- design/store_slicer.sv
// splits one store into lower and upper quadword byte lanes
`timescale 1ns/1ns
`default_nettype none
module store_slicer (
  input  wire logic [2:0]  off_in,
  input  wire logic [1:0]  size_in,
  input  wire logic [63:0] data_in,
  output logic      [7:0]  lo_mask_out,
  output logic      [63:0] lo_data_out,
  output logic      [7:0]  hi_mask_out,
  output logic      [63:0] hi_data_out
);
  logic [15:0]  span;
  logic [127:0] lanes;
  // byte, word, doubleword and quadword all map to a lane mask
  assign span  = 16'((17'h1 << (5'h1 << size_in)) - 17'h1) << off_in;
  assign lanes = {64'h0, data_in} << {off_in, 3'h0};
  assign lo_mask_out = span[7:0];
  assign hi_mask_out = span[15:8];
  assign lo_data_out = lanes[63:0];
  assign hi_data_out = lanes[127:64];
endmodule : store_slicer
`default_nettype wire

//--- design/write_combining_buffer.sv
// single line write-combining buffer between store path and system bus
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - merge stores within one aligned 64-byte line
// - byte, word, doubleword, quadword stores accepted
// - combining type merges in any order
// - writethrough merges ascending, contiguous, one quadword
// - writethrough ends on gap or byte 7
// - uncacheable, write-protected stores never merged
// - closed buffer issues bus writes
// - non-writeback store to other line closes
// - at most one buffer open
// - closed buffer never reopened
// - port input or output closes
// - serializing operations close
// - cache flush forces completion
// - lock start closes; locked stores merge
// - uncacheable load always closes
// - combining load closes on line match
// - memory type change by a non-writeback store closes
// - full 64 bytes closes
// - writethrough closes after 16 idle clocks
// - misaligned writethrough splits lower, upper
// - table reload setting A/D closes
// - full line sent as one write
module write_combining_buffer
  import wcb_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              resetn_in,
  input  wire logic              st_valid_in,
  output logic                   st_ready_out,
  input  wire logic [ADDR_W-1:0] st_addr_in,
  input  wire logic [1:0]        st_size_in,
  input  wire logic [2:0]        st_type_in,
  input  wire logic [63:0]       st_data_in,
  input  wire logic              io_op_in,
  input  wire logic              serialize_in,
  input  wire logic              flush_in,
  input  wire logic              lock_start_in,
  input  wire logic              tlb_ad_set_in,
  input  wire logic              ld_valid_in,
  input  wire logic [2:0]        ld_type_in,
  input  wire logic [ADDR_W-1:0] ld_addr_in,
  input  wire logic              bus_ready_in,
  output logic                   bus_valid_out,
  output logic      [ADDR_W-1:0] bus_addr_out,
  output logic      [7:0]        bus_be_out,
  output logic      [63:0]       bus_data_out,
  output logic                   bus_burst_out,
  output logic                   bus_last_out,
  output logic                   combining_open_out
);
  typedef enum {ST_IDLE, ST_PIECE} piece_state_type;
  typedef logic [LINE_QW-1:0][63:0] line_data_type;
  typedef logic [LINE_QW-1:0][7:0]  line_mask_type;

  wcb_drain_if drn ();

  piece_state_type state_reg, state_next;
  logic            ready_reg, ready_next;
  logic [QA_W-1:0] pc_qa_reg, pc_qa_next;
  logic [7:0]      pc_mask_reg, pc_mask_next, hi_mask_reg, hi_mask_next;
  logic [63:0]     pc_data_reg, pc_data_next, hi_data_reg, hi_data_next;
  mem_type_type    pc_type_reg, pc_type_next, buf_type_reg, buf_type_next;
  logic            open_reg, open_next, ev_pend_reg, ev_pend_next;
  logic [LINE_W-1:0] buf_line_reg, buf_line_next;
  line_data_type   buf_data_reg, buf_data_next;
  line_mask_type   buf_mask_reg, buf_mask_next;
  logic [5:0]      wt_next_reg, wt_next_next;
  logic [4:0]      idle_cnt_reg, idle_cnt_next;
  logic            hand_reg, hand_next;
  logic [LINE_W-1:0] hand_line_reg, hand_line_next;
  line_data_type   hand_data_reg, hand_data_next;
  line_mask_type   hand_mask_reg, hand_mask_next;

  logic [7:0]      lo_mask, hi_mask;
  logic [63:0]     lo_data, hi_data;
  logic [LINE_W-1:0] p_line;
  logic [2:0]      p_qi, p_lo, p_hi;
  logic            free, ev_now, ev_any, timeout, p_comb, conflict;
  logic            m_full, closing, merging;
  line_data_type   m_data, solo_data;
  line_mask_type   m_mask, solo_mask;

  store_slicer u_slicer (
    .off_in      (st_addr_in[2:0]),
    .size_in     (st_size_in),
    .data_in     (st_data_in),
    .lo_mask_out (lo_mask),
    .lo_data_out (lo_data),
    .hi_mask_out (hi_mask),
    .hi_data_out (hi_data)
  );

  bus_write_sender u_sender (
    .core_clk_in   (core_clk_in),
    .resetn_in     (resetn_in),
    .drn           (drn.dst),
    .bus_ready_in  (bus_ready_in),
    .bus_valid_out (bus_valid_out),
    .bus_addr_out  (bus_addr_out),
    .bus_be_out    (bus_be_out),
    .bus_data_out  (bus_data_out),
    .bus_burst_out (bus_burst_out),
    .bus_last_out  (bus_last_out)
  );

  // ********************
  // close conditions
  // ********************
  assign free   = !drn.busy && !hand_reg;
  assign p_line = pc_qa_reg[QA_W-1:3];
  assign p_qi   = pc_qa_reg[2:0];
  assign p_comb = pc_type_reg == combining_memory_type ||
                  pc_type_reg == writethrough_memory_type;
  // a lock closes only at its start, so stores inside it still merge
  assign ev_now = io_op_in || serialize_in || flush_in
                  || lock_start_in || tlb_ad_set_in
                  || (ld_valid_in && ld_type_in == 3'(uncacheable_memory_type))
                  || (ld_valid_in
                      && ld_type_in == 3'(combining_memory_type)
                      && ld_addr_in[ADDR_W-1:6] == buf_line_reg);
  assign ev_any  = ev_now || ev_pend_reg;
  assign timeout = buf_type_reg == writethrough_memory_type
                   && idle_cnt_reg == WT_TIMEOUT_CLKS;

  always_comb begin
    p_lo = 3'h0;
    p_hi = 3'h0;
    for (int b = 7; b >= 0; b--) begin
      if (pc_mask_reg[b]) begin
        p_lo = 3'(b);
      end
    end
    for (int b = 0; b < 8; b++) begin
      if (pc_mask_reg[b]) begin
        p_hi = 3'(b);
      end
    end
    conflict = open_reg && (!p_comb
               || pc_type_reg != buf_type_reg
               || p_line != buf_line_reg
               || (buf_type_reg == writethrough_memory_type
                   && {p_qi, p_lo} != wt_next_reg));
    m_full = 1'b1;
    for (int q = 0; q < LINE_QW; q++) begin
      m_data[q]    = open_reg ? buf_data_reg[q] : 64'h0;
      m_mask[q]    = open_reg ? buf_mask_reg[q] : 8'h00;
      solo_data[q] = 64'h0;
      solo_mask[q] = 8'h00;
      if (q == int'(p_qi)) begin
        solo_data[q] = pc_data_reg;
        solo_mask[q] = pc_mask_reg;
        m_mask[q]    = m_mask[q] | pc_mask_reg;
        for (int b = 0; b < 8; b++) begin
          if (pc_mask_reg[b]) begin
            m_data[q][8*b +: 8] = pc_data_reg[8*b +: 8];
          end
        end
      end
      m_full = m_full & (m_mask[q] == QW_ALL_BYTES);
    end
    closing = m_full
              || (pc_type_reg == writethrough_memory_type
                  && p_hi == WT_LAST_BYTE);
  end

  // ********************
  // piece and buffer control
  // ********************
  always_comb begin
    state_next     = state_reg;
    pc_qa_next     = pc_qa_reg;
    pc_mask_next   = pc_mask_reg;
    pc_data_next   = pc_data_reg;
    pc_type_next   = pc_type_reg;
    hi_mask_next   = hi_mask_reg;
    hi_data_next   = hi_data_reg;
    open_next      = open_reg;
    buf_type_next  = buf_type_reg;
    buf_line_next  = buf_line_reg;
    buf_data_next  = buf_data_reg;
    buf_mask_next  = buf_mask_reg;
    wt_next_next   = wt_next_reg;
    ev_pend_next   = ev_any && open_reg;
    hand_next      = 1'b0;
    hand_line_next = hand_line_reg;
    hand_data_next = hand_data_reg;
    hand_mask_next = hand_mask_reg;
    merging        = 1'b0;
    if (open_reg && (ev_any || timeout)) begin
      if (free) begin
        hand_next      = 1'b1;
        hand_line_next = buf_line_reg;
        hand_data_next = buf_data_reg;
        hand_mask_next = buf_mask_reg;
        open_next      = 1'b0;
        ev_pend_next   = 1'b0;
      end
    end else if (state_reg == ST_PIECE && free) begin
      if (conflict) begin
        // old line leaves first; the piece is retried once the hand-over is done and the sender is free
        hand_next      = 1'b1;
        hand_line_next = buf_line_reg;
        hand_data_next = buf_data_reg;
        hand_mask_next = buf_mask_reg;
        open_next      = 1'b0;
      end else begin
        merging = 1'b1;
        if (!p_comb || closing) begin
          hand_next      = 1'b1;
          hand_line_next = p_line;
          hand_data_next = p_comb ? m_data : solo_data;
          hand_mask_next = p_comb ? m_mask : solo_mask;
          open_next      = 1'b0;
        end else begin
          open_next     = 1'b1;
          buf_type_next = pc_type_reg;
          buf_line_next = p_line;
          buf_data_next = m_data;
          buf_mask_next = m_mask;
          wt_next_next  = 6'({p_qi, p_hi}) + 6'h01;
        end
        if (hi_mask_reg != 8'h00) begin
          pc_qa_next   = pc_qa_reg + QA_W'(1);
          pc_mask_next = hi_mask_reg;
          pc_data_next = hi_data_reg;
          hi_mask_next = 8'h00;
        end else begin
          state_next = ST_IDLE;
        end
      end
    end
    // a store shown with ready high is taken even while a line closes
    if (state_reg == ST_IDLE && st_valid_in && ready_reg) begin
      // writeback stores go to the cache and never touch the buffer
      if (st_type_in != 3'(writeback_memory_type)) begin
        state_next   = ST_PIECE;
        pc_qa_next   = st_addr_in[ADDR_W-1:3];
        pc_type_next = mem_type_type'(st_type_in);
        pc_mask_next = lo_mask;
        pc_data_next = lo_data;
        hi_mask_next = hi_mask;
        hi_data_next = hi_data;
      end
    end
    ready_next = state_next == ST_IDLE;
    if (!open_next || merging || buf_type_next != writethrough_memory_type)
    begin
      idle_cnt_next = CNT_RST;
    end else if (idle_cnt_reg != WT_TIMEOUT_CLKS) begin
      idle_cnt_next = idle_cnt_reg + 5'h01;
    end else begin
      idle_cnt_next = idle_cnt_reg;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      state_reg     <= ST_IDLE;
      ready_reg     <= 1'b0;
      pc_qa_reg     <= '0;
      pc_mask_reg   <= 8'h00;
      pc_data_reg   <= '0;
      pc_type_reg   <= uncacheable_memory_type;
      hi_mask_reg   <= 8'h00;
      hi_data_reg   <= '0;
      open_reg      <= 1'b0;
      ev_pend_reg   <= 1'b0;
      buf_type_reg  <= uncacheable_memory_type;
      buf_line_reg  <= '0;
      buf_data_reg  <= '0;
      buf_mask_reg  <= '0;
      wt_next_reg   <= 6'h00;
      idle_cnt_reg  <= CNT_RST;
      hand_reg      <= 1'b0;
      hand_line_reg <= '0;
      hand_data_reg <= '0;
      hand_mask_reg <= '0;
    end else begin
      state_reg     <= state_next;
      ready_reg     <= ready_next;
      pc_qa_reg     <= pc_qa_next;
      pc_mask_reg   <= pc_mask_next;
      pc_data_reg   <= pc_data_next;
      pc_type_reg   <= pc_type_next;
      hi_mask_reg   <= hi_mask_next;
      hi_data_reg   <= hi_data_next;
      open_reg      <= open_next;
      ev_pend_reg   <= ev_pend_next;
      buf_type_reg  <= buf_type_next;
      buf_line_reg  <= buf_line_next;
      buf_data_reg  <= buf_data_next;
      buf_mask_reg  <= buf_mask_next;
      wt_next_reg   <= wt_next_next;
      idle_cnt_reg  <= idle_cnt_next;
      hand_reg      <= hand_next;
      hand_line_reg <= hand_line_next;
      hand_data_reg <= hand_data_next;
      hand_mask_reg <= hand_mask_next;
    end
  end

  assign drn.start          = hand_reg;
  assign drn.line           = hand_line_reg;
  assign drn.data           = hand_data_reg;
  assign drn.mask           = hand_mask_reg;
  assign st_ready_out       = ready_reg;
  assign combining_open_out = open_reg;

  // ********************
  // checks
  // ********************
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  a_only_comb_open: assert property (
    open_reg |-> buf_type_reg inside {combining_memory_type,
                                      writethrough_memory_type})
    else $error("non-combinable type held open");
  a_full_closes: assert property (
    state_reg == ST_PIECE && free && !conflict && m_full && !ev_any
    && !(open_reg && timeout) |=> !open_reg && hand_reg)
    else $error("full line left open");
  a_wt_byte7: assert property (
    state_reg == ST_PIECE && free && !conflict && !ev_any && p_hi == 3'h7
    && pc_type_reg == writethrough_memory_type |=> !open_reg)
    else $error("writethrough byte 7 did not close");
  a_wt_timeout: assert property (
    open_reg && buf_type_reg == writethrough_memory_type && free
    && idle_cnt_reg == WT_TIMEOUT_CLKS |=> !open_reg)
    else $error("writethrough time-out missed");
  a_wc_no_timeout: assert property (
    open_reg && buf_type_reg == combining_memory_type |-> idle_cnt_reg == 0)
    else $error("combining buffer is timing");
  a_event_closes: assert property (
    (io_op_in || serialize_in || flush_in || lock_start_in || tlb_ad_set_in)
    && open_reg && free |=> !open_reg)
    else $error("completion event left buffer open");
  a_line_change: assert property (
    state_reg == ST_PIECE && open_reg && free && !ev_any && !timeout
    && p_line != buf_line_reg
    |=> hand_reg && hand_line_reg == $past(buf_line_reg) && !open_reg)
    else $error("other line did not close buffer");
  a_one_handover: assert property (
    hand_reg |=> !hand_reg ##1 !hand_reg)
    else $error("two lines handed over back to back");
  a_uc_load: assert property (
    ld_valid_in && ld_type_in == 3'(uncacheable_memory_type) && open_reg
    && free |=> !open_reg)
    else $error("uncacheable load left buffer open");

  c_full_line: cover property (hand_reg && (&hand_mask_reg));
  c_wt_timeout: cover property (open_reg && timeout ##1 !open_reg);
  c_split_store: cover property (state_reg == ST_PIECE
                                 && hi_mask_reg != 8'h00);
  c_uc_store: cover property (merging && !p_comb);
endmodule : write_combining_buffer
`default_nettype wire
